// ==== shared/perf_feedback_pkg.sv ====
// Constants, register map and bus structs for the performance feedback unit.
// Assumes one reference clock at 200 MHz and a small fixed number of logical processors.

package perf_feedback_pkg;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int N_LP     = 2;
  localparam int LP_W     = 1;
  localparam int OP_W     = 16;
  localparam int ACT_IN_W = 5;
  localparam int INC_W    = 6;
  localparam int CNT_W    = 64;
  localparam int BUSY_W   = 16;

  // ---------------------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------------------
  localparam logic [31:0] FIXED_RATE_ADDR    = 32'h0000_00e7;
  localparam logic [31:0] DELIVERED_ADDR     = 32'h0000_00e8;
  localparam logic [31:0] CUR_OP_POINT_ADDR  = 32'h0000_0198;
  localparam logic [31:0] OP_POINT_CTL_ADDR  = 32'h0000_0199;
  localparam logic [31:0] MISC_ENABLES_ADDR  = 32'h0000_01a0;

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int         BOOST_DISABLE_BIT  = 38;
  localparam int         DISENGAGE_BIT      = 32;
  localparam logic [OP_W-1:0] OP_POINT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_RESET     = 64'h0000_0000_0000_0000;

  // ---------------------------------------------------------------------------
  // Feature query
  // ---------------------------------------------------------------------------
  localparam logic [31:0] QUERY_LEAF_POWER  = 32'h0000_0006;
  localparam int          QUERY_ECX_FB_BIT  = 0;
  localparam int          QUERY_EAX_BST_BIT = 1;

  // ---------------------------------------------------------------------------
  // Count rates
  // ---------------------------------------------------------------------------
  localparam logic [INC_W-1:0] NOMINAL_INC = 6'h08;
  localparam logic [INC_W-1:0] BOOST_STEP  = 6'h04;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_PS     = 5000;
  localparam int TRANSITION_NS     = 1000;
  localparam int TRANSITION_CYCLES = (TRANSITION_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic             valid;
    logic             write;
    logic [LP_W-1:0]  lp;
    logic [31:0]      addr;
    logic [63:0]      wdata;
  } reg_req_s;

  typedef struct packed {
    logic             valid;
    logic             err;
    logic [63:0]      rdata;
  } reg_rsp_s;

  typedef struct packed {
    logic [31:0]      eax;
    logic [31:0]      ecx;
  } query_rsp_s;

endpackage

// ==== core/perf_counter_pair.sv ====
// One logical processor's fixed-rate and delivered-performance counters.
// Assumes increments are precomputed by the caller and writes come one per cycle.

`timescale 1ns/1ps

module perf_counter_pair (
  input  wire logic                                    i_ref_clk,   // Reference clock
  input  wire logic                                    i_srst,      // Sync reset, high
  input  wire logic                                    i_c0_active, // Processor in C0
  input  wire logic                                    i_ref_tick,  // Reference rate tick
  input  wire logic [perf_feedback_pkg::INC_W-1:0]     i_fixed_inc, // Fixed-rate step
  input  wire logic [perf_feedback_pkg::INC_W-1:0]     i_act_inc,   // Delivered step
  input  wire logic                                    i_wr_fixed,  // Load fixed counter
  input  wire logic                                    i_wr_act,    // Load delivered counter
  input  wire logic [perf_feedback_pkg::CNT_W-1:0]     i_wdata,     // Load value
  output logic      [perf_feedback_pkg::CNT_W-1:0]     o_fixed,     // Fixed-rate count
  output logic      [perf_feedback_pkg::CNT_W-1:0]     o_act        // Delivered count
);
  import perf_feedback_pkg::*;

  logic [CNT_W:0] fixed_sum;
  logic [CNT_W:0] act_sum;
  logic           counting;
  logic           wrap;

  assign counting  = i_c0_active && i_ref_tick;
  assign fixed_sum = {1'b0, o_fixed} + {{(CNT_W + 1 - INC_W){1'b0}}, i_fixed_inc};
  assign act_sum   = {1'b0, o_act} + {{(CNT_W + 1 - INC_W){1'b0}}, i_act_inc};
  // Either carry clears both, except one loaded by a write that cycle, so the ratio restarts from a common origin
  assign wrap      = counting && (fixed_sum[CNT_W] || act_sum[CNT_W]);

  // ---------------------------------------------------------------------------
  // Fixed-rate counter
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_fixed <= CNT_RESET;
    end else if (i_wr_fixed) begin
      o_fixed <= i_wdata;
    end else if (wrap) begin
      o_fixed <= CNT_RESET;
    end else if (counting) begin
      o_fixed <= fixed_sum[CNT_W-1:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Delivered-performance counter
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_act <= CNT_RESET;
    end else if (i_wr_act) begin
      o_act <= i_wdata;
    end else if (wrap) begin
      o_act <= CNT_RESET;
    end else if (counting) begin
      o_act <= act_sum[CNT_W-1:0];
    end
  end

endmodule // perf_counter_pair

// ==== core/perf_feedback_counters.sv ====
// Performance feedback unit: per-processor counter pairs, operating-point control and boost gating.
// Assumes model-register accesses arrive as one-cycle requests and rate inputs are synchronous.

`timescale 1ns/1ps

module perf_feedback_counters #(
  parameter logic BOOST_SUPPORTED = 1'b1                                  // Part has boost hardware
) (
  input  wire logic                                                i_ref_clk,        // 200 MHz clock
  input  wire logic                                                i_srst,           // Sync reset, high
  input  wire perf_feedback_pkg::reg_req_s                         i_reg_req,        // Register request
  output perf_feedback_pkg::reg_rsp_s                              o_reg_rsp,        // Register answer
  input  wire logic                                                i_query_valid,    // Feature query strobe
  input  wire logic [31:0]                                         i_query_leaf,     // Feature query leaf
  output perf_feedback_pkg::query_rsp_s                            o_query_rsp,      // Feature query data
  output logic                                                     o_query_valid,    // Feature query done
  input  wire logic                                                i_ref_tick,       // Reference rate tick
  input  wire logic [perf_feedback_pkg::N_LP-1:0]                  i_c0_active,      // Per-processor C0
  input  wire logic [perf_feedback_pkg::N_LP-1:0][perf_feedback_pkg::ACT_IN_W-1:0]
                                                                   i_actual_inc,     // Delivered rate
  input  wire logic [perf_feedback_pkg::N_LP-1:0]                  i_headroom_ok,    // Thermal headroom
  input  wire logic [perf_feedback_pkg::N_LP-1:0]                  i_boost_criteria, // Other criteria
  output logic      [perf_feedback_pkg::N_LP-1:0]                  o_boost_active,   // Boost engaged
  output logic      [perf_feedback_pkg::N_LP-1:0]                  o_transition_busy,// Transition running
  output logic      [perf_feedback_pkg::N_LP-1:0][perf_feedback_pkg::OP_W-1:0]
                                                                   o_op_point        // Current point
);
  import perf_feedback_pkg::*;

  localparam logic [BUSY_W-1:0] TRANSITION_LOAD = BUSY_W'(TRANSITION_CYCLES);
  localparam logic [BUSY_W-1:0] BUSY_LAST       = 16'h0001;
  localparam logic [BUSY_W-1:0] BUSY_IDLE       = 16'h0000;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic hit(input reg_req_s req, input logic [31:0] addr, input int lp, input logic wr);
    hit = req.valid && (req.write == wr) && (req.addr == addr) && (int'(req.lp) == lp);
  endfunction

  // Boost never lets the delivered rate fall to or below the nominal rate
  function automatic logic [INC_W-1:0] delivered_step(input logic [ACT_IN_W-1:0] raw, input logic boost);
    logic [INC_W-1:0] base;
    base = {{(INC_W - ACT_IN_W){1'b0}}, raw};
    if (boost && base < NOMINAL_INC) begin
      base = NOMINAL_INC;
    end
    delivered_step = boost ? INC_W'(base + BOOST_STEP) : base;
  endfunction

  function automatic logic known_addr(input logic [31:0] addr);
    known_addr = (addr == FIXED_RATE_ADDR) || (addr == DELIVERED_ADDR) ||
                 (addr == CUR_OP_POINT_ADDR) || (addr == OP_POINT_CTL_ADDR) ||
                 (addr == MISC_ENABLES_ADDR);
  endfunction

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic                                boost_disable_reg;
  logic                                boost_enabled;
  logic [N_LP-1:0]                     disengage_reg;
  logic [N_LP-1:0][OP_W-1:0]           target_reg;
  logic [N_LP-1:0][OP_W-1:0]           in_flight_reg;
  logic [N_LP-1:0][OP_W-1:0]           cur_op_reg;
  logic [N_LP-1:0][BUSY_W-1:0]         busy_reg;
  logic [N_LP-1:0]                     pending_reg;
  logic [N_LP-1:0][CNT_W-1:0]          fixed_cnt;
  logic [N_LP-1:0][CNT_W-1:0]          act_cnt;
  logic [N_LP-1:0]                     ctl_wr;
  logic [63:0]                         rdata_next;

  // ---------------------------------------------------------------------------
  // Package-wide boost enable
  // ---------------------------------------------------------------------------
  // A single copy serves all processors; any processor's write lands here
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      boost_disable_reg <= BOOST_SUPPORTED;
    end else if (i_reg_req.valid && i_reg_req.write && i_reg_req.addr == MISC_ENABLES_ADDR) begin
      boost_disable_reg <= i_reg_req.wdata[BOOST_DISABLE_BIT];
    end
  end

  // Without boost hardware boost stays off whatever the bit holds
  assign boost_enabled = BOOST_SUPPORTED && !boost_disable_reg;

  // ---------------------------------------------------------------------------
  // Per-processor control, transitions and counters
  // ---------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N_LP; g++) begin : gen_lp
      assign ctl_wr[g] = hit(i_reg_req, OP_POINT_CTL_ADDR, g, 1'b1);

      always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
          disengage_reg[g] <= 1'b0;
          target_reg[g]    <= OP_POINT_RESET;
        end else if (ctl_wr[g]) begin
          disengage_reg[g] <= i_reg_req.wdata[DISENGAGE_BIT];
          target_reg[g]    <= i_reg_req.wdata[OP_W-1:0];
        end
      end

      // A write during a transition waits; the latest target starts on completion
      always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
          busy_reg[g]      <= BUSY_IDLE;
          pending_reg[g]   <= 1'b0;
          in_flight_reg[g] <= OP_POINT_RESET;
          cur_op_reg[g]    <= OP_POINT_RESET;
        end else if (busy_reg[g] == BUSY_LAST) begin
          cur_op_reg[g] <= in_flight_reg[g];
          if (pending_reg[g] || ctl_wr[g]) begin
            in_flight_reg[g] <= ctl_wr[g] ? i_reg_req.wdata[OP_W-1:0] : target_reg[g];
            busy_reg[g]      <= TRANSITION_LOAD;
            pending_reg[g]   <= 1'b0;
          end else begin
            busy_reg[g] <= BUSY_IDLE;
          end
        end else if (busy_reg[g] != BUSY_IDLE) begin
          busy_reg[g] <= busy_reg[g] - BUSY_LAST;
          if (ctl_wr[g]) begin
            pending_reg[g] <= 1'b1;
          end
        end else if (ctl_wr[g]) begin
          in_flight_reg[g] <= i_reg_req.wdata[OP_W-1:0];
          busy_reg[g]      <= TRANSITION_LOAD;
        end
      end

      assign o_boost_active[g] = boost_enabled && !disengage_reg[g] &&
                                 i_headroom_ok[g] && i_boost_criteria[g];
      assign o_transition_busy[g] = (busy_reg[g] != BUSY_IDLE);
      assign o_op_point[g]        = cur_op_reg[g];

      perf_counter_pair u_pair (
        .i_ref_clk   (i_ref_clk),
        .i_srst      (i_srst),
        .i_c0_active (i_c0_active[g]),
        .i_ref_tick  (i_ref_tick),
        .i_fixed_inc (NOMINAL_INC),
        .i_act_inc   (delivered_step(i_actual_inc[g], o_boost_active[g])),
        .i_wr_fixed  (hit(i_reg_req, FIXED_RATE_ADDR, g, 1'b1)),
        .i_wr_act    (hit(i_reg_req, DELIVERED_ADDR, g, 1'b1)),
        .i_wdata     (i_reg_req.wdata),
        .o_fixed     (fixed_cnt[g]),
        .o_act       (act_cnt[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Register read path
  // ---------------------------------------------------------------------------
  always_comb begin
    rdata_next = 64'h0;
    case (i_reg_req.addr)
      FIXED_RATE_ADDR:   rdata_next = fixed_cnt[i_reg_req.lp];
      DELIVERED_ADDR:    rdata_next = act_cnt[i_reg_req.lp];
      // Status carries only the point; the disengage bit stays out
      CUR_OP_POINT_ADDR: rdata_next = {48'h0, cur_op_reg[i_reg_req.lp]};
      OP_POINT_CTL_ADDR: begin
        rdata_next                = {48'h0, target_reg[i_reg_req.lp]};
        rdata_next[DISENGAGE_BIT] = disengage_reg[i_reg_req.lp];
      end
      MISC_ENABLES_ADDR: rdata_next[BOOST_DISABLE_BIT] = boost_disable_reg;
      default:           rdata_next = 64'h0;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_reg_rsp <= '0;
    end else begin
      o_reg_rsp.valid <= i_reg_req.valid;
      o_reg_rsp.err   <= i_reg_req.valid && !known_addr(i_reg_req.addr);
      o_reg_rsp.rdata <= (i_reg_req.valid && !i_reg_req.write) ? rdata_next : 64'h0;
    end
  end

  // ---------------------------------------------------------------------------
  // Feature query
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_query_rsp   <= '0;
      o_query_valid <= 1'b0;
    end else begin
      o_query_valid <= i_query_valid;
      o_query_rsp   <= '0;
      if (i_query_valid && i_query_leaf == QUERY_LEAF_POWER) begin
        o_query_rsp.ecx[QUERY_ECX_FB_BIT]  <= 1'b1;
        o_query_rsp.eax[QUERY_EAX_BST_BIT] <= boost_enabled;
      end
    end
  end

endmodule // perf_feedback_counters

// ==== test/perf_feedback_counters_assertions.sv ====
// Concurrent checks on the performance feedback unit's top-level ports.
// Assumes one clock domain and the package constants.

`timescale 1ns/1ps

module perf_feedback_counters_chk (
  input wire logic                                   i_ref_clk,         // Clock
  input wire logic                                   i_srst,            // Sync reset
  input wire perf_feedback_pkg::reg_req_s            i_reg_req,         // Register request
  input wire perf_feedback_pkg::reg_rsp_s            o_reg_rsp,         // Register answer
  input wire logic                                   i_query_valid,     // Query strobe
  input wire logic [31:0]                            i_query_leaf,      // Query leaf
  input wire perf_feedback_pkg::query_rsp_s          o_query_rsp,       // Query data
  input wire logic                                   o_query_valid,     // Query done
  input wire logic [perf_feedback_pkg::N_LP-1:0]     i_headroom_ok,     // Headroom
  input wire logic [perf_feedback_pkg::N_LP-1:0]     i_boost_criteria,  // Criteria
  input wire logic [perf_feedback_pkg::N_LP-1:0]     o_boost_active,    // Boost engaged
  input wire logic [perf_feedback_pkg::N_LP-1:0]     o_transition_busy, // Transition running
  input wire logic [perf_feedback_pkg::N_LP-1:0][perf_feedback_pkg::OP_W-1:0] o_op_point // Current point
);
  import perf_feedback_pkg::*;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  localparam int TCYC = TRANSITION_CYCLES;
  int   busy_run;
  logic known_addr;
  logic ctl_wr0;
  assign known_addr = i_reg_req.addr inside {FIXED_RATE_ADDR, DELIVERED_ADDR, CUR_OP_POINT_ADDR,
                                              OP_POINT_CTL_ADDR, MISC_ENABLES_ADDR};
  assign ctl_wr0 = i_reg_req.valid && i_reg_req.write && i_reg_req.addr == OP_POINT_CTL_ADDR && i_reg_req.lp == 1'b0;

  // Queued writes keep busy high, so a run is a whole number of transitions
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || !o_transition_busy[0]) busy_run <= 0;
    else busy_run <= busy_run + 1;
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  chk_rsp_taken: assert property (i_reg_req.valid |=> o_reg_rsp.valid)
    else $error("register answer missing");
  chk_rsp_origin: assert property (o_reg_rsp.valid |-> $past(i_reg_req.valid))
    else $error("register answer without request");
  chk_unknown_err: assert property (i_reg_req.valid && !known_addr |=> o_reg_rsp.err && o_reg_rsp.rdata == '0)
    else $error("unknown address not refused");
  chk_write_rdata: assert property (i_reg_req.valid && i_reg_req.write |=> o_reg_rsp.rdata == '0)
    else $error("write answer carries data");
  chk_query_present: assert property (i_query_valid && i_query_leaf == QUERY_LEAF_POWER
    |=> o_query_valid && o_query_rsp.ecx[QUERY_ECX_FB_BIT])
    else $error("counter pair not reported");
  chk_query_boost: assert property (i_query_valid && i_query_leaf == QUERY_LEAF_POWER && !i_reg_req.valid
    && (|o_boost_active) |=> o_query_rsp.eax[QUERY_EAX_BST_BIT])
    else $error("boost engaged but reported disabled");
  chk_boost_gate: assert property ((o_boost_active & ~(i_headroom_ok & i_boost_criteria)) == '0)
    else $error("boost engaged without headroom or criteria");
  chk_busy_start: assert property (ctl_wr0 |=> o_transition_busy[0] [*8])
    else $error("control write did not start a transition");
  chk_busy_len: assert property ($fell(o_transition_busy[0]) |-> busy_run % TCYC == 0)
    else $error("transition length wrong");
  chk_point_change: assert property ($changed(o_op_point[0]) |-> $past(o_transition_busy[0]))
    else $error("operating point moved outside a transition");
endmodule // perf_feedback_counters_chk

bind perf_feedback_counters perf_feedback_counters_chk i_chk (
  .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_reg_req(i_reg_req), .o_reg_rsp(o_reg_rsp),
  .i_query_valid(i_query_valid), .i_query_leaf(i_query_leaf), .o_query_rsp(o_query_rsp),
  .o_query_valid(o_query_valid), .i_headroom_ok(i_headroom_ok), .i_boost_criteria(i_boost_criteria),
  .o_boost_active(o_boost_active), .o_transition_busy(o_transition_busy), .o_op_point(o_op_point)
);

// ==== test/perf_feedback_counters_tb.sv ====
// Self-checking bench for the performance feedback unit.
// Assumes the design answers register and query strobes one cycle later.

`timescale 1ns/1ps

module perf_feedback_counters_tb;
  import perf_feedback_pkg::*;

  // ---------------------------------------------------------------------------
  // Signals and bench model
  // ---------------------------------------------------------------------------
  logic                          ref_clk = 1'b0;
  logic                          srst    = 1'b1;
  reg_req_s                      req     = '0;
  reg_rsp_s                      rsp;
  logic                          qv      = 1'b0;
  logic [31:0]                   leaf    = '0;
  query_rsp_s                    qrsp;
  logic                          qdone;
  logic                          tick    = 1'b0;
  logic [N_LP-1:0]               c0      = '0;
  logic [N_LP-1:0][ACT_IN_W-1:0] inc     = '0;
  logic [N_LP-1:0]               hr      = '0;
  logic [N_LP-1:0]               cr      = '0;
  logic [N_LP-1:0]               boost;
  logic [N_LP-1:0]               busy;
  logic [N_LP-1:0][OP_W-1:0]     point;
  logic [CNT_W-1:0]              ef [N_LP];
  logic [CNT_W-1:0]              ea [N_LP];
  logic                          misc38;
  logic [N_LP-1:0]               dis;
  int                            failures = 0;
  int                            checked  = 0;

  always #2.5 ref_clk = ~ref_clk;

  perf_feedback_counters #(.BOOST_SUPPORTED(1'b1)) i_perf_feedback_counters (
    .i_ref_clk(ref_clk), .i_srst(srst), .i_reg_req(req), .o_reg_rsp(rsp), .i_query_valid(qv),
    .i_query_leaf(leaf), .o_query_rsp(qrsp), .o_query_valid(qdone), .i_ref_tick(tick), .i_c0_active(c0),
    .i_actual_inc(inc), .i_headroom_ok(hr), .i_boost_criteria(cr), .o_boost_active(boost),
    .o_transition_busy(busy), .o_op_point(point)
  );

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic test_done;
    if (failures == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask

  function automatic logic [CNT_W-1:0] step(input logic [ACT_IN_W-1:0] i, input logic b);
    if (b) return ((i > NOMINAL_INC) ? i : NOMINAL_INC) + BOOST_STEP;
    return i;
  endfunction

  task automatic acc(input logic w, input int lp, input logic [31:0] a, input logic [63:0] d, input logic [63:0] x);
    logic e;
    e = !(a inside {FIXED_RATE_ADDR, DELIVERED_ADDR, CUR_OP_POINT_ADDR, OP_POINT_CTL_ADDR, MISC_ENABLES_ADDR});
    @(negedge ref_clk);
    req = '{valid: 1'b1, write: w, lp: LP_W'(lp), addr: a, wdata: d};
    @(negedge ref_clk);
    req.valid = 1'b0;
    chk("rsp_valid", 1'b1, rsp.valid);
    chk("rsp_err", e, rsp.err);
    chk("rsp_rdata", (w || e) ? 64'h0 : x, rsp.rdata);
  endtask

  task automatic qry(input logic [31:0] l);
    logic p;
    p = (l == QUERY_LEAF_POWER);
    @(negedge ref_clk);
    qv = 1'b1;
    leaf = l;
    @(negedge ref_clk);
    qv = 1'b0;
    chk("query_valid", 1'b1, qdone);
    chk("query_ecx", {31'h0, p}, qrsp.ecx);
    chk("query_eax", {30'h0, p & !misc38, 1'b0}, qrsp.eax);
  endtask

  // Random rates and gating, boost and counts followed cycle by cycle
  task automatic count(input int n);
    logic [CNT_W:0] sf;
    logic [CNT_W:0] sa;
    logic           b;
    for (int c = 0; c < n; c++) begin
      @(negedge ref_clk);
      tick = 1'b1;
      c0 = N_LP'($urandom);
      hr = N_LP'($urandom);
      cr = N_LP'($urandom);
      inc = (N_LP*ACT_IN_W)'($urandom);
      #1;
      for (int k = 0; k < N_LP; k++) begin
        b = !misc38 && !dis[k] && hr[k] && cr[k];
        chk("boost_active", b, boost[k]);
        sf = {1'b0, ef[k]} + NOMINAL_INC;
        sa = {1'b0, ea[k]} + step(inc[k], b);
        if (c0[k] && (sf[CNT_W] || sa[CNT_W])) begin
          ef[k] = '0;
          ea[k] = '0;
        end else if (c0[k]) begin
          ef[k] = sf[CNT_W-1:0];
          ea[k] = sa[CNT_W-1:0];
        end
      end
    end
    @(negedge ref_clk);
    tick = 1'b0;
  endtask

  task automatic chkcnt;
    for (int k = 0; k < N_LP; k++) begin
      acc(1'b0, k, FIXED_RATE_ADDR, 64'h0, ef[k]);
      acc(1'b0, k, DELIVERED_ADDR, 64'h0, ea[k]);
    end
  endtask

  // ---------------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------------
  initial begin
    void'($urandom(1));
    misc38 = 1'b1;
    dis = '0;
    for (int k = 0; k < N_LP; k++) begin
      ef[k] = '0;
      ea[k] = '0;
    end
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    srst = 1'b0;
    acc(1'b0, 0, MISC_ENABLES_ADDR, 64'h0, 64'(misc38) << BOOST_DISABLE_BIT);
    qry(QUERY_LEAF_POWER);
    qry(32'h0000_0001);
    count(40);
    chkcnt();
    chkcnt();
    // Window start by zeroing each of processor 1's counters on its own
    acc(1'b1, 1, FIXED_RATE_ADDR, 64'h0, 64'h0);
    ef[1] = '0;
    acc(1'b1, 1, DELIVERED_ADDR, 64'h0, 64'h0);
    ea[1] = '0;
    acc(1'b1, 1, MISC_ENABLES_ADDR, 64'h0, 64'h0);
    misc38 = 1'b0;
    qry(QUERY_LEAF_POWER);
    count(40);
    acc(1'b1, 0, DELIVERED_ADDR, 64'h0000_0000_0000_1000, 64'h0);
    ea[0] = 64'h0000_0000_0000_1000;
    chkcnt();
    acc(1'b1, 0, OP_POINT_CTL_ADDR, 64'h0000_0001_0000_1234, 64'h0);
    dis[0] = 1'b1;
    count(20);
    acc(1'b0, 0, OP_POINT_CTL_ADDR, 64'h0, 64'h0000_0001_0000_1234);
    acc(1'b1, 0, OP_POINT_CTL_ADDR, 64'h0000_0000_0000_0055, 64'h0);
    dis[0] = 1'b0;
    acc(1'b0, 0, OP_POINT_CTL_ADDR, 64'h0, 64'h0000_0000_0000_0055);
    for (int t = 0; t < 3 * TRANSITION_CYCLES && busy[0] !== 1'b0; t++) @(negedge ref_clk);
    chk("busy0", 1'b0, busy[0]);
    chk("point0", 16'h0055, point[0]);
    chk("point1", 16'h0000, point[1]);
    acc(1'b0, 0, CUR_OP_POINT_ADDR, 64'h0, 64'h0000_0000_0000_0055);
    count(20);
    acc(1'b1, 0, FIXED_RATE_ADDR, 64'hffff_ffff_ffff_fffc, 64'h0);
    ef[0] = 64'hffff_ffff_ffff_fffc;
    acc(1'b1, 1, DELIVERED_ADDR, 64'hffff_ffff_ffff_ffe8, 64'h0);
    ea[1] = 64'hffff_ffff_ffff_ffe8;
    count(8);
    chkcnt();
    acc(1'b1, 1, 32'h0000_0123, 64'h0000_0000_0000_00ff, 64'h0);
    acc(1'b0, 0, 32'h0000_0123, 64'h0, 64'h0);
    acc(1'b1, 0, MISC_ENABLES_ADDR, 64'h0000_0040_0000_0000, 64'h0);
    misc38 = 1'b1;
    qry(QUERY_LEAF_POWER);
    count(10);
    test_done();
  end

  initial begin
    repeat (10000) @(posedge ref_clk);
    failures++;
    test_done();
  end
endmodule // perf_feedback_counters_tb
